// ---- vid_seq_pkg.sv ----
// shared constants, types and timing counts for the voltage target sequencer
package vid_seq_pkg;

   // clock and time base
   localparam int CLK_PERIOD_NS = 50;

   // status register at protocol offset 0x10, bit 3 flags dac above target
   localparam logic [7:0] STATUS_ONE_OFFSET = 8'h10;
   localparam int         DAC_HIGH_BIT      = 3;
   localparam logic [7:0] STATUS_ONE_RESET  = 8'h00;

   // broadcast addresses
   localparam logic [7:0] BCAST_MEM_ADDR = 8'h0e;
   localparam logic [7:0] BCAST_CPU_ADDR = 8'h0f;

   // voltage code mapping: mv = base + step * code, code 0 means off
   localparam logic [7:0]  CODE_OFF     = 8'h00;
   localparam logic [7:0]  CODE_MAX     = 8'hff;
   localparam logic [11:0] FIVE_MV_BASE = 12'h0f5;   // 245 mv
   localparam logic [11:0] FIVE_MV_STEP = 12'h005;
   localparam logic [11:0] TEN_MV_BASE  = 12'h1ea;   // 490 mv
   localparam logic [11:0] TEN_MV_STEP  = 12'h00a;
   localparam logic [11:0] DAC_HIGH_MARGIN_MV = 12'h01e;  // 30 mv

   // reporting offset ranges (current in quarter amps, temp in degrees)
   localparam logic [7:0] REPORT_MAX = 8'hff;

   // timing figures as printed, then cycle counts
   localparam int T_EN_TO_LOOP1_NS  = 3000;
   localparam int T_RAMP_TO_RDY_NS  = 1000;
   localparam int T_TRACK_STEP_NS   = 2660;
   localparam int T_SLEW_TICK_NS    = 1000;
   localparam int EN_TO_LOOP1_CYC   = (T_EN_TO_LOOP1_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
   localparam int RAMP_TO_RDY_CYC   = T_RAMP_TO_RDY_NS / CLK_PERIOD_NS;
   localparam int TRACK_STEP_CYC    = T_TRACK_STEP_NS / CLK_PERIOD_NS;
   localparam int SLEW_TICK_CYC     = T_SLEW_TICK_NS / CLK_PERIOD_NS;

   // selectable inter-loop delays in microseconds
   localparam int SEQ_DLY_250US  = 250;
   localparam int SEQ_DLY_500US  = 500;
   localparam int SEQ_DLY_1MS    = 1000;
   localparam int SEQ_DLY_2P5MS  = 2500;
   localparam int SEQ_DLY_5MS    = 5000;
   localparam int SEQ_DLY_10MS   = 10000;
   localparam int NS_PER_US      = 1000;

   // loop start order
   typedef enum logic [1:0] {
      ORDER_TOGETHER,
      ORDER_L2_AFTER_L1,
      ORDER_L1_AFTER_L2
   } start_order_e;

   // broadcast response per loop
   typedef enum logic [1:0] {
      BCAST_BOTH,
      BCAST_MEM_ONLY,
      BCAST_CPU_ONLY,
      BCAST_NONE
   } bcast_cfg_e;

   // command kinds from the serial bus or the management port
   typedef enum logic [1:0] {
      CMD_NONE,
      CMD_SET_VOLTAGE,
      CMD_POWER_STATE
   } cmd_kind_e;

   localparam logic [1:0] DEEPEST_POWER_STATE = 2'h3;

   // decoded command carrier
   typedef struct packed {
      logic       valid;
      cmd_kind_e  kind;
      logic       to_loop2;
      logic [7:0] addr;
      logic [7:0] data;
   } cmd_s;

   // per-loop configuration carrier
   typedef struct packed {
      logic [7:0]        boot_code;
      logic signed [7:0] code_offset;
      logic [7:0]        vmax_code;
      logic [7:0]        slew_mv;
      bcast_cfg_e        bcast;
   } loop_cfg_s;

endpackage : vid_seq_pkg

// ---- vid_code_adjust.sv ----
// offset, saturation, limit and code to millivolt mapping for one loop
`timescale 1ns/1ps
`default_nettype none
module vid_code_adjust
   import vid_seq_pkg::*;
(
   // requested code and its adjustments
   input  wire logic [7:0]        code_in,
   input  wire logic signed [7:0] code_offset,
   input  wire logic [7:0]        vmax_code,
   input  wire logic              ten_mv,
   // adjusted result
   output logic [7:0]             code_out,
   output logic [11:0]            target_mv
);

   logic signed [9:0] sum;       // code plus offset, wide enough to not wrap
   logic [7:0]        sat;       // sum held in 0..ff

   // combine, saturate, clamp and map
   always_comb begin
      sum = $signed({2'b00, code_in}) + 10'(code_offset);
      if (sum < 0) begin
         sat = CODE_OFF;
      end else if (sum > $signed({2'b00, CODE_MAX})) begin
         // ten mv tops out at ff
         sat = CODE_MAX;
      end else begin
         sat = sum[7:0];
      end
      if (code_in == CODE_OFF) begin
         code_out = CODE_OFF;
      end else if (sat > vmax_code) begin
         code_out = vmax_code;   // the limit wins, even over a large offset
      end else begin
         code_out = sat;
      end
      if (code_out == CODE_OFF) begin
         target_mv = 12'h000;
      end else if (ten_mv) begin
         target_mv = TEN_MV_BASE + TEN_MV_STEP * {4'h0, code_out};
      end else begin
         target_mv = FIVE_MV_BASE + FIVE_MV_STEP * {4'h0, code_out};
      end
   end

endmodule : vid_code_adjust
`default_nettype wire

// ---- loop_ramp.sv ----
// slewed ramp of one loop's dac toward its millivolt target
`timescale 1ns/1ps
`default_nettype none
module loop_ramp
   import vid_seq_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // control
   input  wire logic        go,
   input  wire logic        tick,
   input  wire logic [11:0] target_mv,
   input  wire logic [7:0]  slew_mv,
   // state
   output logic [11:0]      dac_mv,
   output logic             done
);

   typedef struct packed {
      logic [11:0] dac;    // present dac value in mv
   } ramp_state_s;

   ramp_state_s state_reg;
   ramp_state_s state_next;
   logic [11:0] goal;      // target while running, zero once stopped
   logic [11:0] diff;      // distance still to travel

   // next dac value: step by slew per tick, never overshoot
   always_comb begin
      state_next = state_reg;
      goal       = go ? target_mv : 12'h000;
      diff       = (state_reg.dac > goal) ? state_reg.dac - goal
                                          : goal - state_reg.dac;
      if (tick) begin
         if (diff <= {4'h0, slew_mv}) begin
            state_next.dac = goal;
         end else if (state_reg.dac < goal) begin
            state_next.dac = state_reg.dac + {4'h0, slew_mv};
         end else begin
            state_next.dac = state_reg.dac - {4'h0, slew_mv};
         end
      end
   end

   // state register
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign dac_mv = state_reg.dac;
   assign done   = go && (state_reg.dac == target_mv);

endmodule : loop_ramp
`default_nettype wire

// ---- vid_target_and_loop_sequencer.sv ----
// voltage target, reporting offsets and two-loop start sequencer
// Summary of operation
// - signed code offset, -128 to +127
// - ten mv profile never above 3.04 V
// - current report offset, quarter amp steps
// - temperature report offset, one degree steps
// - per loop broadcast 0E/0F response choice
// - cpu loop answers 0F, memory 0E
// - ten mv profile takes configured boot code
// - mobile boot code in five or ten mv
// - status bit 3 when dac 30mV high, mobile profile only
// - deepest state accepted, circuitry stays powered in mobile profile only, else shuts down
// - loops start together or in order
// - inter-loop delay from seven choices
// - tracking loop 2 is half loop 1
// - tracking control from serial or management
// - tracking boot above zero ramps, readies
// - independent slew per loop
// - first loop starts 3us after enable
// - ready within 1us of ramp done
// - tracking loop 2 delay, 2.66us steps (code uses 53 cycles, 2.65us per step)
// - five mv: FF 1.52V, 47 0.6V
// - ten mv: FF 3.04V, 10mV steps
`timescale 1ns/1ps
`default_nettype none
module vid_target_and_loop_sequencer
   import vid_seq_pkg::*;
#(
   // inter-loop delays in cycles
   parameter int DLY_250US_CYC = SEQ_DLY_250US * NS_PER_US / CLK_PERIOD_NS,
   parameter int DLY_500US_CYC = SEQ_DLY_500US * NS_PER_US / CLK_PERIOD_NS,
   parameter int DLY_1MS_CYC   = SEQ_DLY_1MS * NS_PER_US / CLK_PERIOD_NS,
   parameter int DLY_2P5MS_CYC = SEQ_DLY_2P5MS * NS_PER_US / CLK_PERIOD_NS,
   parameter int DLY_5MS_CYC   = SEQ_DLY_5MS * NS_PER_US / CLK_PERIOD_NS,
   parameter int DLY_10MS_CYC  = SEQ_DLY_10MS * NS_PER_US / CLK_PERIOD_NS
)(
   // clock and reset
   input  wire logic             clock,
   input  wire logic             sys_rst,
   // regulator enable pin, asynchronous
   input  wire logic             regulator_enable_input,
   // profile selection from the nonvolatile config store
   input  wire logic             ten_mv_code_profile,
   input  wire logic             mobile_profile,
   input  wire logic             mobile_boot_10mv,
   input  wire logic             memory_tracking_mode,
   // sequencing configuration
   input  wire start_order_e     start_order,
   input  wire logic [2:0]       seq_delay_sel,
   input  wire logic [7:0]       track_delay_code,
   // per loop configuration
   input  wire loop_cfg_s        loop1_cfg,
   input  wire loop_cfg_s        loop2_cfg,
   // reporting offsets
   input  wire logic [7:0]       raw_current,
   input  wire logic signed [4:0] current_offset,
   input  wire logic [7:0]       raw_temp,
   input  wire logic signed [5:0] temp_offset,
   // command sources
   input  wire logic             host_present,
   input  wire cmd_s             serial_cmd,
   input  wire cmd_s             mgmt_cmd,
   // loop outputs
   output logic                  loop1_ready_output,
   output logic                  loop2_ready_output,
   output logic [11:0]           loop1_dac_mv,
   output logic [11:0]           loop2_dac_mv,
   // status and reporting
   output logic [7:0]            protocol_status_one,
   output logic                  loop1_bcast_hit,
   output logic                  loop2_bcast_hit,
   output logic [7:0]            reported_current,
   output logic [7:0]            reported_temp,
   output logic [1:0]            power_state,
   output logic                  circuitry_shutdown
);

   ////////////////////////////////////////////////////////////////////////
   // state
   typedef enum logic [1:0] {
      SEQ_IDLE,     // enable low, loops off
      SEQ_LEAD,     // enable seen, waiting before the first loop
      SEQ_GAP,      // first loop running, second one held back
      SEQ_RUN       // both loops released
   } seq_state_e;

   typedef struct packed {
      logic        en_meta;     // first synchroniser stage
      logic        en_sync;     // second synchroniser stage
      seq_state_e  st;
      logic [17:0] cnt;         // lead and gap counter
      logic [4:0]  tick_cnt;    // slew tick divider
      logic        tick;
      logic        go1, go2;
      logic        rdy1, rdy2;
      logic [7:0]  code1;       // requested code loop 1
      logic [7:0]  code2;       // requested code loop 2
      logic        setv_seen;   // a loop 1 set command since enable
      logic [7:0]  status;
      logic        bc1, bc2;
      logic [7:0]  cur_rep;
      logic [7:0]  temp_rep;
      logic [1:0]  pstate;
      logic        shut;
   } seq_s;

   seq_s        state_reg;
   seq_s        state_next;

   cmd_s        cmd;             // selected command source
   logic        ten_mv;          // effective step size
   logic [11:0] mv1;             // loop 1 target in mv
   logic [11:0] mv2_own;         // loop 2 own target in mv
   logic [11:0] mv2;             // loop 2 target actually used
   logic [11:0] dac1, dac2;      // present ramp values
   logic        done1, done2;
   logic [17:0] gap_len;         // cycles from first to second go
   logic signed [9:0] cur_sum, temp_sum;  // report sums, never wrap

   ////////////////////////////////////////////////////////////////////////
   // datapath helpers
   // ten mv profile, boot code used
   assign ten_mv = ten_mv_code_profile
                   || (mobile_profile && mobile_boot_10mv);
   assign cmd = host_present ? serial_cmd : mgmt_cmd;
   // only the millivolt target is used; the code itself is not needed
   vid_code_adjust u_adjust1 (
      .code_in     (state_reg.code1),
      .code_offset (loop1_cfg.code_offset),
      .vmax_code   (loop1_cfg.vmax_code),
      .ten_mv      (ten_mv),
      .code_out    (),
      .target_mv   (mv1)
   );
   vid_code_adjust u_adjust2 (
      .code_in     (state_reg.code2),
      .code_offset (loop2_cfg.code_offset),
      .vmax_code   (loop2_cfg.vmax_code),
      .ten_mv      (ten_mv),
      .code_out    (),
      .target_mv   (mv2_own)
   );
   assign mv2 = memory_tracking_mode ? {1'b0, mv1[11:1]} : mv2_own;
   // each loop has its own slew
   loop_ramp u_ramp1 (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .go        (state_reg.go1),
      .tick      (state_reg.tick),
      .target_mv (mv1),
      .slew_mv   (loop1_cfg.slew_mv),
      .dac_mv    (dac1),
      .done      (done1)
   );
   loop_ramp u_ramp2 (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .go        (state_reg.go2),
      .tick      (state_reg.tick),
      .target_mv (mv2),
      .slew_mv   (loop2_cfg.slew_mv),
      .dac_mv    (dac2),
      .done      (done2)
   );

   // gap length: tracking step count, else the selectable table
   always_comb begin
      if (memory_tracking_mode) begin
         gap_len = 18'({10'h000, track_delay_code} * TRACK_STEP_CYC);
      end else begin
         case (seq_delay_sel)
            3'h0:    gap_len = 18'h00000;
            3'h1:    gap_len = 18'(DLY_250US_CYC);
            3'h2:    gap_len = 18'(DLY_500US_CYC);
            3'h3:    gap_len = 18'(DLY_1MS_CYC);
            3'h4:    gap_len = 18'(DLY_2P5MS_CYC);
            3'h5:    gap_len = 18'(DLY_5MS_CYC);
            default: gap_len = 18'(DLY_10MS_CYC);
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      state_next = state_reg;
      // enable pin passes two flops before anything reads it
      state_next.en_meta = regulator_enable_input;
      state_next.en_sync = state_reg.en_meta;

      // slew tick every microsecond
      state_next.tick     = state_reg.tick_cnt == 5'(SLEW_TICK_CYC - 1);
      state_next.tick_cnt = state_next.tick ? 5'h00
                                            : state_reg.tick_cnt + 5'h01;

      // sequencer
      case (state_reg.st)
         SEQ_IDLE: begin
            state_next.code1 = loop1_cfg.boot_code;
            state_next.code2 = loop2_cfg.boot_code;
            state_next.cnt   = 18'h00000;
            // tracking waits for boot above zero
            if (state_reg.en_sync && !(memory_tracking_mode
                   && loop1_cfg.boot_code == CODE_OFF)) begin
               state_next.st = SEQ_LEAD;
            end
         end
         SEQ_LEAD: begin
            // first loop starts 3us after enable
            if (state_reg.cnt == 18'(EN_TO_LOOP1_CYC - 1)) begin
               state_next.cnt = 18'h00000;
               if (memory_tracking_mode
                   || start_order == ORDER_L2_AFTER_L1) begin
                  state_next.go1 = 1'b1;
                  state_next.st  = SEQ_GAP;
               end else if (start_order == ORDER_L1_AFTER_L2) begin
                  state_next.go2 = 1'b1;
                  state_next.st  = SEQ_GAP;
               end else begin
                  state_next.go1 = 1'b1;
                  state_next.go2 = 1'b1;
                  state_next.st  = SEQ_RUN;
               end
            end else begin
               state_next.cnt = state_reg.cnt + 18'h00001;
            end
         end
         SEQ_GAP: begin
            // second loop released after the gap
            if (state_reg.cnt >= gap_len) begin
               state_next.go1 = 1'b1;
               state_next.go2 = 1'b1;
               state_next.st  = SEQ_RUN;
            end else begin
               state_next.cnt = state_reg.cnt + 18'h00001;
            end
         end
         SEQ_RUN: begin
            // set commands retarget a loop once both loops run
            if (cmd.valid && cmd.kind == CMD_SET_VOLTAGE) begin
               if (cmd.to_loop2) begin
                  state_next.code2 = cmd.data;
               end else begin
                  state_next.code1     = cmd.data;
                  state_next.setv_seen = 1'b1;
               end
            end
         end
         default: begin
            state_next.st = SEQ_IDLE;
         end
      endcase

      // enable low drops both loops and their ready at once
      if (!state_reg.en_sync) begin
         state_next.st        = SEQ_IDLE;
         state_next.go1       = 1'b0;
         state_next.go2       = 1'b0;
         state_next.setv_seen = 1'b0;
      end

      // ready one cycle after ramp done
      state_next.rdy1 = state_next.go1 && done1;
      state_next.rdy2 = state_next.go2 && done2;

      // dac more than 30mV over set target
      state_next.status = STATUS_ONE_RESET;
      state_next.status[DAC_HIGH_BIT] = mobile_profile && state_reg.setv_seen
         && (dac1 > mv1 + DAC_HIGH_MARGIN_MV);

      // memory role 0E, cpu role 0F
      state_next.bc1 = cmd.valid && (
         (cmd.addr == BCAST_MEM_ADDR
            && loop1_cfg.bcast inside {BCAST_BOTH, BCAST_MEM_ONLY})
         || (cmd.addr == BCAST_CPU_ADDR
            && loop1_cfg.bcast inside {BCAST_BOTH, BCAST_CPU_ONLY}));
      state_next.bc2 = cmd.valid && (
         (cmd.addr == BCAST_MEM_ADDR
            && loop2_cfg.bcast inside {BCAST_BOTH, BCAST_MEM_ONLY})
         || (cmd.addr == BCAST_CPU_ADDR
            && loop2_cfg.bcast inside {BCAST_BOTH, BCAST_CPU_ONLY}));

      cur_sum = $signed({2'b00, raw_current}) + 10'(current_offset);
      state_next.cur_rep = (cur_sum < 0) ? 8'h00
         : (cur_sum > $signed({2'b00, REPORT_MAX})) ? REPORT_MAX
         : cur_sum[7:0];
      temp_sum = $signed({2'b00, raw_temp}) + 10'(temp_offset);
      state_next.temp_rep = (temp_sum < 0) ? 8'h00
         : (temp_sum > $signed({2'b00, REPORT_MAX})) ? REPORT_MAX
         : temp_sum[7:0];

      // power state commands are always accepted
      if (cmd.valid && cmd.kind == CMD_POWER_STATE) begin
         state_next.pstate = cmd.data[1:0];
      end
      state_next.shut = (state_next.pstate == DEEPEST_POWER_STATE)
                        && !mobile_profile;
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from flops
   assign loop1_ready_output  = state_reg.rdy1;
   assign loop2_ready_output  = state_reg.rdy2;
   assign loop1_dac_mv        = dac1;
   assign loop2_dac_mv        = dac2;
   assign protocol_status_one = state_reg.status;
   assign loop1_bcast_hit     = state_reg.bc1;
   assign loop2_bcast_hit     = state_reg.bc2;
   assign reported_current    = state_reg.cur_rep;
   assign reported_temp       = state_reg.temp_rep;
   assign power_state         = state_reg.pstate;
   assign circuitry_shutdown  = state_reg.shut;

endmodule : vid_target_and_loop_sequencer
`default_nettype wire

// ---- host_model.sv ----
// processor-side model issuing decoded serial bus commands
`timescale 1ns/1ps
`default_nettype none
module host_model
   import vid_seq_pkg::*;
(
   // clock and command toward the device
   input  wire logic clock,
   output var  cmd_s cmd
);
   initial cmd = '0;
   // one command, valid for exactly one cycle
   task automatic send(input cmd_kind_e k, input logic l2,
                       input logic [7:0] a, d);
      @(negedge clock);
      cmd = '{1'b1, k, l2, a, d};
      @(negedge clock);
      // idle fields are scrambled: only valid may qualify them
      cmd = '{1'b0, CMD_NONE, ~l2, ~a, ~d};
   endtask : send
endmodule : host_model
`default_nettype wire

// ---- vid_seq_assertions.sv ----
// port-level checks for the voltage target sequencer
`timescale 1ns/1ps
`default_nettype none
module vid_seq_assertions
   import vid_seq_pkg::*;
(
   // clock, reset and mode
   input wire logic              clock,
   input wire logic              sys_rst,
   input wire logic              mobile_profile,
   // commands and loop 1 setup
   input wire logic              host_present,
   input wire cmd_s              serial_cmd,
   input wire cmd_s              mgmt_cmd,
   input wire loop_cfg_s         loop1_cfg,
   // reporting inputs
   input wire logic [7:0]        raw_current,
   input wire logic signed [4:0] current_offset,
   input wire logic [7:0]        raw_temp,
   input wire logic signed [5:0] temp_offset,
   // outputs watched
   input wire logic [11:0]       loop1_dac_mv,
   input wire logic [7:0]        protocol_status_one,
   input wire logic              loop1_bcast_hit,
   input wire logic              loop2_bcast_hit,
   input wire logic [7:0]        reported_current,
   input wire logic [7:0]        reported_temp,
   input wire logic [1:0]        power_state,
   input wire logic              circuitry_shutdown
);
   default clocking dc @(posedge clock); endclocking
   default disable iff (sys_rst);
   //////////////////////////////////////////////////////////////////
   cmd_s       sel;   // command from the source in charge
   int         cs;    // raw current plus offset
   int         ts;    // raw temperature plus offset
   logic [7:0] csat;  // sums clamped to 0..255
   logic [7:0] tsat;
   // sums kept wide so saturation is judged before truncation
   always_comb begin
      sel  = host_present ? serial_cmd : mgmt_cmd;
      cs   = int'(raw_current) + int'(current_offset);
      ts   = int'(raw_temp) + int'(temp_offset);
      csat = cs < 0 ? 8'h00 : (cs > 255 ? 8'hff : cs[7:0]);
      tsat = ts < 0 ? 8'h00 : (ts > 255 ? 8'hff : ts[7:0]);
   end
   // a command to one broadcast address
   sequence s_cmd_to(a);
      sel.valid && sel.addr == a;
   endsequence
   AST_CURR_SAT: assert property (
      1'b1 |=> reported_current == $past(csat)) else $error("current off");
   AST_TEMP_SAT: assert property (
      1'b1 |=> reported_temp == $past(tsat)) else $error("temp off");
   AST_DAC_CEIL: assert property (
      loop1_dac_mv <= 12'hbe0) else $error("dac above ceiling");
   AST_FLAG_MOBILE: assert property (
      !mobile_profile [*2] |-> !protocol_status_one[DAC_HIGH_BIT])
      else $error("dac flag outside mobile");
   AST_NO_SHUT_MOBILE: assert property (
      mobile_profile [*2] |-> !circuitry_shutdown) else $error("shut");
   AST_DEEP_SHUT: assert property (
      (power_state == DEEPEST_POWER_STATE && !mobile_profile) [*3]
      |-> circuitry_shutdown) else $error("deep state kept powered");
   AST_HIT_CAUSE: assert property (
      !sel.valid |=> !loop1_bcast_hit && !loop2_bcast_hit)
      else $error("hit without command");
   AST_CPU_ADDR_GATE: assert property (
      s_cmd_to(BCAST_CPU_ADDR) ##0
      loop1_cfg.bcast inside {BCAST_BOTH, BCAST_CPU_ONLY}
      |=> loop1_bcast_hit) else $error("loop 1 missed 0f");
endmodule : vid_seq_assertions
`default_nettype wire

// ---- testbench.sv ----
// bench: start-up orders, targets, reports and commands
`timescale 1ns/1ps
`default_nettype none
module testbench
   import vid_seq_pkg::*;
;
   // nets named as the sequencer ports
   logic clock, sys_rst, regulator_enable_input, ten_mv_code_profile;
   logic mobile_profile, mobile_boot_10mv, memory_tracking_mode;
   logic host_present, loop1_ready_output, loop2_ready_output;
   logic loop1_bcast_hit, loop2_bcast_hit, circuitry_shutdown;
   start_order_e      start_order;
   logic [2:0]        seq_delay_sel;
   logic [7:0]        track_delay_code, raw_current, raw_temp;
   loop_cfg_s         loop1_cfg, loop2_cfg;
   logic signed [4:0] current_offset;
   logic signed [5:0] temp_offset;
   cmd_s              serial_cmd, mgmt_cmd;
   logic [11:0]       loop1_dac_mv, loop2_dac_mv;
   logic [7:0]        protocol_status_one, reported_current, reported_temp;
   logic [1:0]        power_state;
   int                error_cnt = 0;
   int                num_checks = 0;
   // delays shortened: 20 to 120 cycles for selections 1 to 6
   vid_target_and_loop_sequencer #(.DLY_250US_CYC(20), .DLY_500US_CYC(40),
      .DLY_1MS_CYC(60), .DLY_2P5MS_CYC(80), .DLY_5MS_CYC(100),
      .DLY_10MS_CYC(120)) u_dut (.clock, .sys_rst, .regulator_enable_input,
      .ten_mv_code_profile, .mobile_profile, .mobile_boot_10mv,
      .memory_tracking_mode, .start_order, .seq_delay_sel, .track_delay_code,
      .loop1_cfg, .loop2_cfg, .raw_current, .current_offset, .raw_temp,
      .temp_offset, .host_present, .serial_cmd, .mgmt_cmd,
      .loop1_ready_output, .loop2_ready_output, .loop1_dac_mv, .loop2_dac_mv,
      .protocol_status_one, .loop1_bcast_hit, .loop2_bcast_hit,
      .reported_current, .reported_temp, .power_state, .circuitry_shutdown);
   host_model u_host (.clock, .cmd(serial_cmd));
   //////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      if (error_cnt == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [11:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic ok(input logic cond);
      chk({11'h0, cond}, 12'h1);
   endtask : ok
   // reset, enable, time each dac's start, wait for ready
   task automatic t_start(input start_order_e o, input logic [2:0] s,
                          input logic trk);
      int c1, c2;
      c1 = 0;
      c2 = 0;
      {sys_rst, regulator_enable_input, memory_tracking_mode} = {2'b10, trk};
      start_order = o;
      seq_delay_sel = s;
      repeat (5) @(negedge clock);
      {sys_rst, regulator_enable_input} = 2'b01;
      for (int i = 1; i < 3000 && !(loop1_ready_output &&
           loop2_ready_output); i++) begin
         @(negedge clock);
         if (loop1_dac_mv == 12'h000) c1 = i;
         if (loop2_dac_mv == 12'h000) c2 = i;
      end
      if (!(loop1_ready_output && loop2_ready_output)) begin
         error_cnt++;
         end_of_test;
      end
      if (o != ORDER_L1_AFTER_L2) ok(c1 >= 60 && c1 <= 90);
      if (!trk && o == ORDER_TOGETHER) ok(c1 == c2);
      if (o == ORDER_L2_AFTER_L1) ok(c2 > c1 + 100);
      if (o == ORDER_L1_AFTER_L2) ok(c1 > c2 + 100);
      chk(loop1_dac_mv, 12'hbe0);
      chk(loop2_dac_mv, trk ? 12'h5f0 : 12'h64a);
   endtask : t_start
   task automatic rep(input logic [7:0] r, input logic [4:0] oi,
                      input logic [5:0] ot, input logic [7:0] ei, et);
      {raw_current, raw_temp} = {r, r};
      current_offset = oi;
      temp_offset = ot;
      repeat (2) @(negedge clock);
      chk({4'h0, reported_current}, {4'h0, ei});
      chk({4'h0, reported_temp}, {4'h0, et});
   endtask : rep
   task automatic t_cmd;
      u_host.send(CMD_POWER_STATE, 1'b0, BCAST_CPU_ADDR, 8'h00);
      chk({10'h0, loop1_bcast_hit, loop2_bcast_hit}, 12'h2);
      u_host.send(CMD_POWER_STATE, 1'b0, BCAST_MEM_ADDR, 8'h00);
      chk({10'h0, loop1_bcast_hit, loop2_bcast_hit}, 12'h1);
      host_present = 1'b0;
      mgmt_cmd = '{1'b1, CMD_POWER_STATE, 1'b0, BCAST_CPU_ADDR, 8'h00};
      @(negedge clock);
      mgmt_cmd.valid = 1'b0;
      chk({10'h0, loop1_bcast_hit, loop2_bcast_hit}, 12'h2);
      {host_present, mobile_profile} = 2'b11;
      // target well below the falling dac
      u_host.send(CMD_SET_VOLTAGE, 1'b0, BCAST_CPU_ADDR, 8'h80);
      repeat (3) @(negedge clock);
      ok(protocol_status_one[DAC_HIGH_BIT]);
      u_host.send(CMD_POWER_STATE, 1'b0, BCAST_CPU_ADDR, 8'h03);
      @(negedge clock);
      chk({10'h0, power_state}, 12'h3);
      ok(!circuitry_shutdown);
      mobile_profile = 1'b0;
      repeat (3) @(negedge clock);
      ok(circuitry_shutdown);
   endtask : t_cmd
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      {ten_mv_code_profile, mobile_profile, mobile_boot_10mv} = 3'b100;
      {host_present, raw_current, raw_temp} = 17'h10000;
      {current_offset, temp_offset, track_delay_code} = 19'h00002;
      mgmt_cmd = '0;
      // limit at top so offset fits; loop 2 slew half
      loop1_cfg = '{8'hff, 8'h05, 8'hff, 8'hc8, BCAST_CPU_ONLY};
      loop2_cfg = '{8'h80, 8'hff, 8'h70, 8'h64, BCAST_MEM_ONLY};
      t_start(ORDER_TOGETHER, 3'h0, 1'b0);
      t_start(ORDER_L1_AFTER_L2, 3'h7, 1'b0);
      t_start(ORDER_L2_AFTER_L1, 3'h6, 1'b0);
      rep(8'h02, 5'h10, 6'h20, 8'h00, 8'h00);
      rep(8'hfd, 5'h0f, 6'h1f, 8'hff, 8'hff);
      rep(8'h40, 5'h1f, 6'h03, 8'h3f, 8'h43);
      t_cmd;
      track_delay_code = 8'h03;
      t_start(ORDER_L2_AFTER_L1, 3'h1, 1'b1);
      end_of_test;
   end
endmodule : testbench
bind vid_target_and_loop_sequencer vid_seq_assertions u_chk (.clock,
   .sys_rst, .mobile_profile, .host_present, .serial_cmd, .mgmt_cmd,
   .loop1_cfg, .raw_current, .current_offset, .raw_temp, .temp_offset,
   .loop1_dac_mv, .protocol_status_one, .loop1_bcast_hit, .loop2_bcast_hit,
   .reported_current, .reported_temp, .power_state, .circuitry_shutdown);
`default_nettype wire
